/* File: bench/reset_nmi_checker.sv */
`timescale 1ns/1ps
module reset_nmi_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        reset_input_pin_i,
	input wire logic        reset_input_pin_o,
	input wire logic        reset_input_pin_oe,
	input wire logic        reset_indication_output,
	input wire logic        nmi_pin,
	input wire logic        core_reset,
	input wire logic        nmi_trap,
	input wire logic        power_down
);
	logic [2:0] since_end_of_init_instruction;
	logic       end_of_init_instruction_wr;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	assign end_of_init_instruction_wr = psel && penable && pready && pwrite
		&& paddr == reset_nmi_pkg::cmd_off
		&& pwdata[reset_nmi_pkg::cmd_end_of_init_instruction_bit];

	// saturating age of the last end-of-init write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since_end_of_init_instruction <= 3'h7;
		else if (end_of_init_instruction_wr)
			since_end_of_init_instruction <= 3'h0;
		else if (since_end_of_init_instruction != 3'h7)
			since_end_of_init_instruction <= since_end_of_init_instruction + 3'h1;
	end

	////////////////////////////////////////////////////////////////////
	AST_RST_ENTER:
		assert property ((!reset_input_pin_i && !reset_input_pin_oe) [*4]
			|-> ##[0:4] core_reset)
		else $error("pin low did not reset core");
	AST_GLITCH:
		assert property ($rose(reset_input_pin_i)
			&& $past(reset_input_pin_i, 2) && !core_reset
			|-> !core_reset [*5])
		else $error("short pin pulse caused reset");
	AST_OE_DRIVE:
		assert property (reset_input_pin_oe |-> !reset_input_pin_o
			&& (core_reset || $past(core_reset)))
		else $error("pin driven outside reset sequence");
	AST_OE_END:
		assert property ($fell(reset_input_pin_oe) |-> ##[0:1] !core_reset)
		else $error("pin released before sequence end");
	AST_IND_LOW:
		assert property (core_reset && $past(core_reset)
			|-> !reset_indication_output)
		else $error("indication high during reset");
	AST_IND_REL:
		assert property ($rose(reset_indication_output)
			|-> since_end_of_init_instruction < 3'h4)
		else $error("indication released without end of init");
	AST_NMI:
		assert property ($fell(nmi_pin) && reset_indication_output
			|-> ##[2:6] nmi_trap)
		else $error("no trap after interrupt edge");
	AST_POWER_DOWN_INSTRUCTION:
		assert property ($rose(power_down) |-> !nmi_pin)
		else $error("power down entered with interrupt pin high");
endmodule // reset_nmi_checker

bind reset_nmi_control reset_nmi_checker chk_u (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .paddr(paddr), .pwdata(pwdata),
	.reset_input_pin_i(reset_input_pin_i),
	.reset_input_pin_o(reset_input_pin_o),
	.reset_input_pin_oe(reset_input_pin_oe),
	.reset_indication_output(reset_indication_output),
	.nmi_pin(nmi_pin), .core_reset(core_reset), .nmi_trap(nmi_trap),
	.power_down(power_down));

/* File: bench/reset_source_model.sv */
`timescale 1ns/1ps
module reset_source_model (
	input  wire logic pclk,
	input  wire logic dev_oe,
	output wire logic pin_level,
	output logic      nmi_level
);
	logic ext_low;

	// open-drain wire with pull-up: low while either side sinks it
	assign pin_level = !(ext_low || dev_oe);

	initial begin
		ext_low = 1'b0;
		nmi_level = 1'b1;
	end

	// one cycle is 8 ns, below the filter limit; 15 or more is safe
	task automatic hold_low(input int n);
		ext_low <= 1'b1;
		repeat (n) @(posedge pclk);
		ext_low <= 1'b0;
	endtask

	task automatic set_nmi(input logic v);
		nmi_level <= v;
	endtask
endmodule // reset_source_model

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        err;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        oe;
	logic        ind;
	logic        nmi;
	logic        boot;
	logic        core_reset;
	logic        trap;
	logic        pdn;
	logic        boot_go;
	logic        irq;
	int          n_mismatch;
	int          total_checks;
	int          k;

	reset_nmi_control #(.seq_len(8)) dut_u (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.reset_input_pin_i(pin), .reset_input_pin_o(),
		.reset_input_pin_oe(oe), .reset_indication_output(ind),
		.nmi_pin(nmi), .bootstrap_select_pin(boot),
		.core_reset(core_reset), .nmi_trap(trap), .power_down(pdn),
		.bootstrap_start(boot_go), .irq(irq));
	reset_source_model src_u (.pclk(pclk), .dev_oe(oe),
		.pin_level(pin), .nmi_level(nmi));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] bit_of(input int b);
		return 32'h0000_0001 << b;
	endfunction

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge keeps the next call off this time step
		@(posedge pclk);
	endtask

	task automatic cmd(input int b);
		apb(1'b1, reset_nmi_pkg::cmd_off, bit_of(b));
		repeat (3) @(posedge pclk);
	endtask

	task automatic wait_run();
		while (core_reset !== 1'b0)
			@(posedge pclk);
		repeat (2) @(posedge pclk);
	endtask

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wait_run();
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		k = $urandom(92);
		{presetn, psel, penable, pwrite, paddr} = '0;
		pwdata = $urandom;
		boot = 1'b1;
		n_mismatch = 0;
		total_checks = 0;
		do_reset();
		check("ind", 0, ind);
		apb(1'b1, reset_nmi_pkg::ctrl_off, 32'h0000_0001);
		apb(1'b1, reset_nmi_pkg::mask_off, 32'h0000_0007);
		cmd(reset_nmi_pkg::cmd_end_of_init_instruction_bit);
		check("ind", 1, ind);
		apb(1'b1, reset_nmi_pkg::ctrl_off, $urandom & 32'hFFFF_FFFE);
		apb(1'b0, reset_nmi_pkg::ctrl_off, 0);
		check("ctrl", 1, rd);
		apb(1'b0, 8'h3C, 0);
		check("slverr", 1, err);
		// interrupt edge, then read-clear drops the level
		src_u.set_nmi(1'b0);
		repeat (8) @(posedge pclk);
		check("irq", 1, irq);
		apb(1'b0, reset_nmi_pkg::status_off, 0);
		check("status", bit_of(0), rd & 32'h7);
		repeat (2) @(posedge pclk);
		check("irq", 0, irq);
		src_u.set_nmi(1'b1);
		repeat (4) @(posedge pclk);
		cmd(reset_nmi_pkg::cmd_power_down_instruction_bit);
		check("pdown", 0, pdn);
		apb(1'b0, reset_nmi_pkg::status_off, 0);
		check("status", bit_of(2), rd & 32'h7);
		src_u.set_nmi(1'b0);
		repeat (8) @(posedge pclk);
		cmd(reset_nmi_pkg::cmd_power_down_instruction_bit);
		check("pdown", 1, pdn);
		apb(1'b0, reset_nmi_pkg::status_off, 0);
		check("status", 32'h3, rd & 32'h7);
		// short pin pulse in bidirectional mode is stretched
		src_u.set_nmi(1'b1);
		k = $urandom % 2;
		boot <= k[0];
		src_u.hold_low(5);
		repeat (3) @(posedge pclk);
		check("oe", 1, oe);
		check("core", 1, core_reset);
		wait_run();
		check("ind", 0, ind);
		check("boot", !k[0], boot_go);
		apb(1'b0, reset_nmi_pkg::cause_off, 0);
		check("cause", 1, rd & 32'hF);
		// the finished sequence has cleared the bidirectional bit
		apb(1'b0, reset_nmi_pkg::ctrl_off, 0);
		check("ctrl", 0, rd);
		apb(1'b1, reset_nmi_pkg::ctrl_off, 32'h0000_0001);
		cmd(reset_nmi_pkg::cmd_end_of_init_instruction_bit);
		cmd(reset_nmi_pkg::cmd_wdtrst_bit);
		check("oe", 1, oe);
		wait_run();
		apb(1'b0, reset_nmi_pkg::cause_off, 0);
		check("cause", 1, rd & 32'hF);
		boot <= 1'b1;
		// power-on reset clears the bidirectional bit
		do_reset();
		cmd(reset_nmi_pkg::cmd_end_of_init_instruction_bit);
		cmd(reset_nmi_pkg::cmd_swrst_bit);
		check("oe", 0, oe);
		check("ind", 0, ind);
		wait_run();
		cmd(reset_nmi_pkg::cmd_end_of_init_instruction_bit);
		src_u.hold_low(1);
		repeat (6) @(posedge pclk);
		check("core", 0, core_reset);
		src_u.hold_low(15 + $urandom % 16);
		check("core", 1, core_reset);
		wait_run();
		apb(1'b0, reset_nmi_pkg::cause_off, 0);
		check("cause", 1, rd & 32'h1);
		conclude();
	end

	// the sequence needs well under 1000 cycles; allow twenty times that
	initial begin
		#160000;
		n_mismatch++;
		conclude();
	end
endmodule // tb_top

/* File: verilog/reset_nmi_control.sv */
`timescale 1ns/1ps
module reset_nmi_control #(
	parameter int seq_len = reset_nmi_pkg::seq_cycles
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        reset_input_pin_i,
	output logic             reset_input_pin_o,
	output logic             reset_input_pin_oe,
	output logic             reset_indication_output,
	input  wire logic        nmi_pin,
	input  wire logic        bootstrap_select_pin,
	output logic             core_reset,
	output logic             nmi_trap,
	output logic             power_down,
	output logic             bootstrap_start,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic rst_meta;
	logic rst_sync;
	logic nmi_meta;
	logic nmi_sync;
	logic nmi_prev;
	logic boot_meta;
	logic boot_sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_meta  <= 1'b1;
			rst_sync  <= 1'b1;
			nmi_meta  <= 1'b1;
			nmi_sync  <= 1'b1;
			nmi_prev  <= 1'b1;
			boot_meta <= 1'b1;
			boot_sync <= 1'b1;
		end else begin
			rst_meta  <= reset_input_pin_i;
			rst_sync  <= rst_meta;
			nmi_meta  <= nmi_pin;
			nmi_sync  <= nmi_meta;
			nmi_prev  <= nmi_sync;
			boot_meta <= bootstrap_select_pin;
			boot_sync <= boot_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// spike filter: low must persist to count; sub-filter lows vanish

	localparam int flt_w = $clog2(reset_nmi_pkg::long_rst_cycles + 2);
	localparam logic [flt_w-1:0] flt_min =
		flt_w'(reset_nmi_pkg::filter_cycles);
	localparam logic [flt_w-1:0] flt_long =
		flt_w'(reset_nmi_pkg::long_rst_cycles);

	logic [flt_w-1:0] low_cnt;
	logic             pin_low;
	logic             pin_long;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt  <= '0;
			pin_low  <= 1'b0;
			pin_long <= 1'b0;
		end else if (rst_sync) begin
			low_cnt  <= '0;
			pin_low  <= 1'b0;
			pin_long <= 1'b0;
		end else begin
			if (low_cnt != flt_long)
				low_cnt <= low_cnt + 1'b1;
			if (low_cnt >= flt_min)
				pin_low <= 1'b1;
			if (low_cnt >= flt_long - 1'b1)
				pin_long <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset sequencer

	localparam int seq_w = $clog2(seq_len + 1);

	reset_nmi_pkg::seq_state_t state;
	reset_nmi_pkg::cpu_cmd_t   cmd;
	logic [seq_w-1:0]          seq_cnt;
	logic                      bidir_reset_enable;
	logic                      own_drive;
	logic                      hw_trig;
	logic                      sw_trig;
	logic                      wdt_trig;
	logic                      any_trig;

	assign hw_trig  = pin_low && !own_drive;
	assign sw_trig  = cmd.swrst;
	assign wdt_trig = cmd.wdtrst;
	assign any_trig = hw_trig || sw_trig || wdt_trig;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= reset_nmi_pkg::st_reset;
			seq_cnt <= '0;
		end else begin
			case (state)
				reset_nmi_pkg::st_reset: begin
					// pin still held low keeps the sequence from ending while own_drive is clear
					if (hw_trig)
						seq_cnt <= '0;
					else if (seq_cnt == seq_w'(seq_len - 1))
						state <= reset_nmi_pkg::st_init;
					else
						seq_cnt <= seq_cnt + 1'b1;
				end
				reset_nmi_pkg::st_init: begin
					if (any_trig) begin
						state   <= reset_nmi_pkg::st_reset;
						seq_cnt <= '0;
					end else if (cmd.end_of_init_instruction)
						state <= reset_nmi_pkg::st_run;
				end
				reset_nmi_pkg::st_run: begin
					if (any_trig) begin
						state   <= reset_nmi_pkg::st_reset;
						seq_cnt <= '0;
					end else if (cmd.power_down_instruction && !nmi_sync)
						state <= reset_nmi_pkg::st_pdown;
				end
				reset_nmi_pkg::st_pdown: begin
					// only a hardware reset leaves power-down
					if (hw_trig) begin
						state   <= reset_nmi_pkg::st_reset;
						seq_cnt <= '0;
					end
				end
				default: begin
					state   <= reset_nmi_pkg::st_reset;
					seq_cnt <= '0;
				end
			endcase
		end
	end

	// mask our own pull from hw_trig until the synchroniser and the
	// filter have seen the released pin high again (three cycles)
	logic [2:0] drive_tail;
	assign own_drive = reset_input_pin_oe || (|drive_tail);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_tail         <= 3'h0;
			reset_input_pin_oe <= 1'b0;
			reset_input_pin_o  <= 1'b0;
		end else begin
			drive_tail <= {drive_tail[1:0], reset_input_pin_oe};
			reset_input_pin_oe <= bidir_reset_enable &&
				(state == reset_nmi_pkg::st_reset);
			reset_input_pin_o  <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset              <= 1'b1;
			reset_indication_output <= 1'b0;
			power_down              <= 1'b0;
		end else begin
			core_reset <= (state == reset_nmi_pkg::st_reset) ||
				any_trig;
			reset_indication_output <=
				(state == reset_nmi_pkg::st_run ||
				 state == reset_nmi_pkg::st_pdown) &&
				!any_trig;
			power_down <= (state == reset_nmi_pkg::st_pdown);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cause flags and boot sampling

	logic [5:0] cause;
	logic       seq_end;

	assign seq_end = (state == reset_nmi_pkg::st_reset) && !hw_trig &&
		(seq_cnt == seq_w'(seq_len - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause           <= 6'h01;
			bootstrap_start <= 1'b0;
		end else begin
			if (any_trig && state != reset_nmi_pkg::st_reset) begin
				cause <= '0;
				if (bidir_reset_enable || (hw_trig && pin_long))
					cause[reset_nmi_pkg::cause_hw_long_bit] <= 1'b1;
				else if (hw_trig)
					cause[reset_nmi_pkg::cause_hw_short_bit] <= 1'b1;
				else if (sw_trig)
					cause[reset_nmi_pkg::cause_sw_bit] <= 1'b1;
				else
					cause[reset_nmi_pkg::cause_wdt_bit] <= 1'b1;
			end
			if (state == reset_nmi_pkg::st_reset && pin_long &&
			    cause[reset_nmi_pkg::cause_hw_short_bit]) begin
				cause[reset_nmi_pkg::cause_hw_short_bit] <= 1'b0;
				cause[reset_nmi_pkg::cause_hw_long_bit]  <= 1'b1;
			end
			if (seq_end) begin
				// config only resampled on hardware-like resets
				if (cause[reset_nmi_pkg::cause_hw_long_bit] ||
				    cause[reset_nmi_pkg::cause_hw_short_bit]) begin
					cause[reset_nmi_pkg::cause_boot_bit] <= !boot_sync;
					bootstrap_start <= !boot_sync;
				end
			end
			if (state == reset_nmi_pkg::st_init && cmd.end_of_init_instruction && !any_trig) begin
				cause[reset_nmi_pkg::cause_end_of_init_instruction_bit] <= 1'b1;
				bootstrap_start <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// nmi edge detect

	logic nmi_fall;

	assign nmi_fall = nmi_prev && !nmi_sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			nmi_trap <= 1'b0;
		else
			nmi_trap <= nmi_fall && (state == reset_nmi_pkg::st_run ||
				state == reset_nmi_pkg::st_init);
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave

	logic                          wr_en;
	logic                          rd_en;
	logic [reset_nmi_pkg::irq_width-1:0] status;
	logic [reset_nmi_pkg::irq_width-1:0] mask;
	logic [reset_nmi_pkg::irq_width-1:0] events;
	logic                          addr_ok;

	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && penable && !pwrite && pready;
	assign addr_ok = (paddr == reset_nmi_pkg::ctrl_off) ||
		(paddr == reset_nmi_pkg::cause_off) ||
		(paddr == reset_nmi_pkg::status_off) ||
		(paddr == reset_nmi_pkg::mask_off) ||
		(paddr == reset_nmi_pkg::cmd_off);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end

	// command pulses last one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd <= '0;
		else if (wr_en && paddr == reset_nmi_pkg::cmd_off) begin
			cmd.end_of_init_instruction  <= pwdata[reset_nmi_pkg::cmd_end_of_init_instruction_bit];
			cmd.power_down_instruction  <= pwdata[reset_nmi_pkg::cmd_power_down_instruction_bit];
			cmd.swrst  <= pwdata[reset_nmi_pkg::cmd_swrst_bit];
			cmd.wdtrst <= pwdata[reset_nmi_pkg::cmd_wdtrst_bit];
		end else
			cmd <= '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bidir_reset_enable <=
				reset_nmi_pkg::ctrl_reset[reset_nmi_pkg::ctrl_bidir_bit];
		else if (seq_end)
			bidir_reset_enable <= 1'b0;
		else if (wr_en && paddr == reset_nmi_pkg::ctrl_off &&
			state == reset_nmi_pkg::st_init)
			bidir_reset_enable <=
				pwdata[reset_nmi_pkg::ctrl_bidir_bit];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask <= reset_nmi_pkg::mask_reset;
		else if (wr_en && paddr == reset_nmi_pkg::mask_off)
			mask <= pwdata[reset_nmi_pkg::irq_width-1:0];
	end

	assign events[reset_nmi_pkg::irq_nmi_bit] = nmi_fall;
	assign events[reset_nmi_pkg::irq_power_down_instruction_bit] =
		state == reset_nmi_pkg::st_run && cmd.power_down_instruction && !nmi_sync && !any_trig;
	assign events[reset_nmi_pkg::irq_pwrrej_bit] =
		state == reset_nmi_pkg::st_run && cmd.power_down_instruction && nmi_sync;

	// set beats the clear-on-read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status <= '0;
		else if (rd_en && paddr == reset_nmi_pkg::status_off)
			status <= (status & ~prdata[reset_nmi_pkg::irq_width-1:0]) | events;
		else
			status <= status | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata  <= 32'h0000_0000;
			pslverr <= psel && !penable && !addr_ok;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					reset_nmi_pkg::ctrl_off:
						prdata <= {31'h0000_0000, bidir_reset_enable};
					reset_nmi_pkg::cause_off:
						prdata <= {26'h000_0000, cause};
					reset_nmi_pkg::status_off:
						prdata <= {29'h0000_0000, status};
					reset_nmi_pkg::mask_off:
						prdata <= {29'h0000_0000, mask};
					default:
						prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // reset_nmi_control

/* File: verilog/reset_nmi_pkg.sv */
package reset_nmi_pkg;

	// register byte offsets
	localparam logic [7:0] ctrl_off    = 8'h00;
	localparam logic [7:0] cause_off   = 8'h04;
	localparam logic [7:0] status_off  = 8'h08;
	localparam logic [7:0] mask_off    = 8'h0C;
	localparam logic [7:0] cmd_off     = 8'h10;

	// control register fields
	localparam int ctrl_bidir_bit = 0;

	// command register fields (write one to trigger)
	localparam int cmd_end_of_init_instruction_bit  = 0;
	localparam int cmd_power_down_instruction_bit  = 1;
	localparam int cmd_swrst_bit  = 2;
	localparam int cmd_wdtrst_bit = 3;

	// cause register fields
	localparam int cause_hw_long_bit  = 0;
	localparam int cause_hw_short_bit = 1;
	localparam int cause_sw_bit       = 2;
	localparam int cause_wdt_bit      = 3;
	localparam int cause_boot_bit     = 4;
	localparam int cause_end_of_init_instruction_bit    = 5;

	// interrupt status fields
	localparam int irq_nmi_bit     = 0;
	localparam int irq_power_down_instruction_bit   = 1;
	localparam int irq_pwrrej_bit  = 2;
	localparam int irq_width       = 3;

	// reset values
	localparam logic [31:0] ctrl_reset   = 32'h0000_0000;
	localparam logic [2:0]  mask_reset   = 3'h0;

	// timing
	localparam int clk_mhz           = 125;
	localparam int filter_ns         = 10;
	localparam int filter_cycles     = (filter_ns * clk_mhz + 999) / 1000;
	localparam int long_rst_ns       = 100;
	localparam int long_rst_cycles   = (long_rst_ns * clk_mhz + 999) / 1000;
	localparam int seq_cycles        = 1024;

	typedef enum logic [1:0] {
		st_reset = 2'b00,
		st_init  = 2'b01,
		st_run   = 2'b11,
		st_pdown = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic end_of_init_instruction;
		logic power_down_instruction;
		logic swrst;
		logic wdtrst;
	} cpu_cmd_t;

endpackage
